// ===== rtl/audio_tx_defines.svh
// Constants for the serial audio master that feeds the transmitter audio input.
// Operation
// - Device is slave; three selectable framing formats.
// - I2S: MSB on second rising edge.
// - I2S: left while sync low, right high.
// - Left-justified: MSB on first rising edge.
// - Left-justified: left while sync high, first.
// - Remaining bits follow, descending, one per clock.
// - DSP: one-period sync pulse, right follows left.
// - Bit clock above 1 MHz while enabled.
// - Set nonzero rate only after clock runs.
// - Zero the rate before stopping the clock.
// - Ordering violated means device reset required.
`ifndef AUDIO_TX_DEFINES_SVH
`define AUDIO_TX_DEFINES_SVH

// ============================================================
// Clocking
`define MCLK_MHZ        125
`define BCLK_HALF_CYC   6'd20
`define SETTLE_NS       10000
`define SETTLE_CYC      ((`SETTLE_NS * `MCLK_MHZ + 999) / 1000)

// ============================================================
// Frame layout
`define SLOT_BITS       6'd32
`define LAST_POS        6'h3F
`define SAMPLE_MSB      23

// ============================================================
// Rate codes presented as the sample-rate setting
`define RATE_OFF        3'h0
`define RATE_32K        3'h1
`define RATE_40K        3'h2
`define RATE_44K1       3'h3
`define RATE_48K        3'h4

// ============================================================
// Buffer
`define FIFO_DEPTH      32
`define FIFO_WIDTH      48

`endif

// ===== rtl/audio_tx_pkg.sv
// Types shared by the serial audio master and its user.
package audio_tx_pkg;

  typedef enum logic [1:0] {
    FMT_I2S,
    FMT_LEFT_JUST,
    FMT_DSP
  } audio_fmt_e;

  typedef enum logic [1:0] {
    WLEN_8,
    WLEN_16,
    WLEN_20,
    WLEN_24
  } word_len_e;

  typedef struct packed {
    logic [23:0] left;
    logic [23:0] right;
  } stereo_pair_s;

  typedef struct packed {
    audio_fmt_e  fmt;
    logic        dsp_late;
    word_len_e   wlen;
    logic [2:0]  rate;
  } link_cfg_s;

endpackage

// ===== rtl/audio_serial_master.sv
// Serial audio master: sample FIFO, bit clock divider, framer and enable sequencing.
`timescale 1ns/100ps
`include "audio_tx_defines.svh"

// ============================================================
// Sample buffer
module audio_pair_fifo #(
  parameter int WIDTH = `FIFO_WIDTH,
  parameter int DEPTH = `FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  // Empty comes from the occupancy count; ready is a flop kept below.
  assign out_valid = (count_q != '0);
  assign out_data  = mem[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage array; written only on an accepted push.
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // Pointers and occupancy.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wr_q     <= '0;
      rd_q     <= '0;
      count_q  <= '0;
      in_ready <= 1'b1;
    end else begin
      // Full is predicted a cycle ahead, so ready leaves the block straight from a flop.
      in_ready <= !((push && !pop && (count_q == (AW+1)'(DEPTH - 1))) || (!in_ready && !pop));
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule

// ============================================================
// Link master
module audio_serial_master (
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      sys_rst,
  // Configuration, captured when streaming is enabled
  input  wire logic                      stream_enable,
  input  audio_tx_pkg::link_cfg_s        link_cfg,
  // Sample stream
  input  wire logic                      pair_valid,
  output logic                           pair_ready,
  input  audio_tx_pkg::stereo_pair_s     pair_data,
  // Device pins
  output logic                           audio_bit_clock,
  output logic                           audio_frame_sync,
  output logic                           audio_data,
  // Device setting and status
  output logic [2:0]                     rate_setting,
  output logic                           link_active,
  output logic                           underrun
);
  import audio_tx_pkg::*;

  typedef enum logic [2:0] {
    SEQ_OFF,
    SEQ_CLK_UP,
    SEQ_RUN,
    SEQ_RATE_DOWN,
    SEQ_CLK_STOP
  } seq_e;

  localparam logic [13:0] SETTLE = 14'(`SETTLE_CYC);

  // ============================================================
  // Helper functions

  // Word length in bits for a length code.
  function automatic logic [5:0] wlen_bits(input word_len_e w);
    case (w)
      WLEN_8:  wlen_bits = 6'd8;
      WLEN_16: wlen_bits = 6'd16;
      WLEN_20: wlen_bits = 6'd20;
      default: wlen_bits = 6'd24;
    endcase
  endfunction

  // True when a frame position lies inside a word that starts at 'start'.
  function automatic logic in_word(input logic [5:0] pos, input logic [5:0] start, input logic [5:0] len);
    logic [6:0] p7;
    logic [6:0] s7;
    p7 = {1'b0, pos};
    s7 = {1'b0, start};
    in_word = (p7 >= s7) && (p7 < s7 + {1'b0, len});
  endfunction

  // Bit of an MSB-aligned sample carried at a frame position.
  function automatic logic word_bit(input logic [23:0] w, input logic [5:0] pos, input logic [5:0] start);
    logic [5:0] idx;
    idx = 6'(`SAMPLE_MSB) - (pos - start);
    word_bit = w[idx[4:0]];
  endfunction

  // ============================================================
  // State
  seq_e         seq_q;
  link_cfg_s    cfg_q;
  logic [13:0]  settle_q;
  logic [5:0]   div_q;
  logic         bclk_q;
  logic         clk_run_q;
  logic [5:0]   pos_q;
  stereo_pair_s cur_q;
  logic         fs_q;
  logic         data_q;
  logic [2:0]   rate_q;
  logic         underrun_q;

  // Fifo drain side.
  logic         head_valid;
  logic         head_pop;
  logic [47:0]  head_raw;
  stereo_pair_s head;

  // Edge timing.
  logic         half_done;
  logic         fall_edge;
  logic [5:0]   next_pos;
  logic         frame_wrap;

  // Word placement for the frame being sent.
  logic [5:0]   len;
  logic [5:0]   left_start;
  logic [5:0]   right_start;
  stereo_pair_s word_src;
  logic         fs_d;
  logic         data_d;

  audio_pair_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .in_valid  (pair_valid),
    .in_ready  (pair_ready),
    .in_data   (pair_data),
    .out_valid (head_valid),
    .out_ready (head_pop),
    .out_data  (head_raw)
  );

  assign head = stereo_pair_s'(head_raw);

  // ============================================================
  // Bit clock divider
  // The link clock is made here from mclk, so the link logic shares mclk and
  // needs no crossing; the pin is a registered copy of the divider phase.
  assign half_done  = (div_q == `BCLK_HALF_CYC - 6'd1);
  assign fall_edge  = clk_run_q && half_done && bclk_q;
  assign next_pos   = pos_q + 6'd1;
  assign frame_wrap = (pos_q == `LAST_POS);

  // clock above 1 MHz: 125 MHz / 40 gives 3.125 MHz.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      div_q  <= '0;
      bclk_q <= 1'b0;
    end else if (!clk_run_q) begin
      div_q  <= '0;
      bclk_q <= 1'b0;
    end else if (half_done) begin
      div_q  <= '0;
      bclk_q <= !bclk_q;
    end else begin
      div_q <= div_q + 6'd1;
    end
  end

  // ============================================================
  // Enable sequencer
  // The rate setting only goes nonzero once the clock has run for a settle
  // time, and returns to zero a settle time before the clock is stopped.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      seq_q     <= SEQ_OFF;
      clk_run_q <= 1'b0;
      rate_q    <= `RATE_OFF;
      settle_q  <= '0;
      cfg_q     <= '0;
    end else begin
      case (seq_q)
        SEQ_OFF: begin
          if (stream_enable) begin
            cfg_q     <= link_cfg;
            clk_run_q <= 1'b1;
            settle_q  <= '0;
            seq_q     <= SEQ_CLK_UP;
          end
        end
        SEQ_CLK_UP: begin
          if (settle_q == SETTLE - 14'd1) begin
            rate_q <= cfg_q.rate;
            seq_q  <= SEQ_RUN;
          end else begin
            settle_q <= settle_q + 14'd1;
          end
        end
        SEQ_RUN: begin
          if (!stream_enable) begin
            rate_q   <= `RATE_OFF;
            settle_q <= '0;
            seq_q    <= SEQ_RATE_DOWN;
          end
        end
        SEQ_RATE_DOWN: begin
          if (settle_q == SETTLE - 14'd1) begin
            seq_q <= SEQ_CLK_STOP;
          end else begin
            settle_q <= settle_q + 14'd1;
          end
        end
        SEQ_CLK_STOP: begin
          if (fall_edge && frame_wrap) begin
            clk_run_q <= 1'b0;
            seq_q     <= SEQ_OFF;
          end
        end
        default: begin
          seq_q     <= SEQ_OFF;
          clk_run_q <= 1'b0;
          rate_q    <= `RATE_OFF;
        end
      endcase
    end
  end

  // ============================================================
  // Framer
  // Pairs are taken only while the device has a nonzero rate; the settle window
  // after enable carries silence, but a pair still being sent when the rate drops is lost.
  // pair per frame
  assign head_pop = fall_edge && frame_wrap && (seq_q == SEQ_RUN) && head_valid;

  always_comb begin
    len = wlen_bits(cfg_q.wlen);
    case (cfg_q.fmt)
      FMT_I2S: begin
        left_start  = 6'd1;
        right_start = `SLOT_BITS + 6'd1;
      end
      FMT_LEFT_JUST: begin
        left_start  = 6'd0;
        right_start = `SLOT_BITS;
      end
      default: begin
        left_start  = cfg_q.dsp_late ? 6'd2 : 6'd1;
        right_start = left_start + len;
      end
    endcase
  end

  // The word source for position zero is the pair about to be loaded.
  always_comb begin
    if (frame_wrap) begin
      word_src = head_pop ? head : '0;
    end else begin
      word_src = cur_q;
    end
  end

  // Level of sync and data for the position that begins at this falling edge.
  always_comb begin
    case (cfg_q.fmt)
      FMT_I2S:       fs_d = (next_pos >= `SLOT_BITS);
      FMT_LEFT_JUST: fs_d = (next_pos < `SLOT_BITS);
      default:       fs_d = (next_pos == 6'd0);
    endcase
    if (in_word(next_pos, left_start, len)) begin
      data_d = word_bit(word_src.left, next_pos, left_start);
    end else if (in_word(next_pos, right_start, len)) begin
      data_d = word_bit(word_src.right, next_pos, right_start);
    end else begin
      data_d = 1'b0;
    end
  end

  // Position counter; it parks at the last position so the first falling
  // edge after the clock starts opens a fresh frame.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pos_q <= `LAST_POS;
    end else if (!clk_run_q) begin
      pos_q <= `LAST_POS;
    end else if (fall_edge) begin
      pos_q <= next_pos;
    end
  end

  // Current pair register.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cur_q <= '0;
    end else if (fall_edge && frame_wrap) begin
      cur_q <= word_src;
    end
  end

  // Pin registers; sync and data change on falling edges so they are steady
  // at the rising edge on which the device samples.
  // controller is master
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      fs_q   <= 1'b0;
      data_q <= 1'b0;
    end else if (!clk_run_q) begin
      fs_q   <= 1'b0;
      data_q <= 1'b0;
    end else if (fall_edge) begin
      fs_q   <= fs_d;
      data_q <= data_d;
    end
  end

  // A frame boundary in the run state with nothing buffered sends silence.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      underrun_q <= 1'b0;
    end else begin
      underrun_q <= fall_edge && frame_wrap && (seq_q == SEQ_RUN) && !head_valid;
    end
  end

  // ============================================================
  // Outputs
  // rate zero from reset
  assign rate_setting     = rate_q;
  assign audio_bit_clock  = bclk_q;
  assign audio_frame_sync = fs_q;
  assign audio_data       = data_q;
  assign link_active      = clk_run_q;
  assign underrun         = underrun_q;

endmodule

// ===== verification/audio_link_chk.sv
// Concurrent checks on the serial audio master ports.
`timescale 1ns/100ps

// ============================================================
// Checker
module audio_link_chk (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       sys_rst,
  // Control
  input wire logic       stream_enable,
  // Link and status
  input wire logic       audio_bit_clock,
  input wire logic       audio_frame_sync,
  input wire logic       audio_data,
  input wire logic [2:0] rate_setting,
  input wire logic       link_active,
  input wire logic       underrun
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // Twenty cycles each way keeps the bit clock far above the 1 MHz floor.
  a_bclk_high_time: assert property ($rose(audio_bit_clock) |-> audio_bit_clock[*8] ##1 audio_bit_clock[*8]
    ##1 audio_bit_clock[*4] ##1 !audio_bit_clock) else $error("bit clock high time wrong");
  a_bclk_low_time: assert property ($fell(audio_bit_clock) |-> !audio_bit_clock[*8] ##1 !audio_bit_clock[*8]
    ##1 !audio_bit_clock[*4]) else $error("bit clock low time wrong");
  // Only a change just after a falling edge is accepted, since the device samples on the rise.
  a_sync_on_fall: assert property (link_active && $past(link_active) && $changed(audio_frame_sync)
    |-> !audio_bit_clock && $past(audio_bit_clock, 2)) else $error("frame sync moved off a falling edge");
  a_data_on_fall: assert property (link_active && $past(link_active) && $changed(audio_data)
    |-> !audio_bit_clock && $past(audio_bit_clock, 2)) else $error("data moved off a falling edge");
  a_off_rate_zero: assert property (!link_active |-> rate_setting == 3'h0)
    else $error("rate set while link idle");
  a_rate_after_clk: assert property ($changed(rate_setting) && rate_setting != 3'h0
    |-> $past(link_active, 300)) else $error("rate set before clock ran");
  a_rate_drop_first: assert property (link_active && rate_setting != 3'h0 && !stream_enable
    |=> rate_setting == 3'h0) else $error("rate not cleared on disable");
  a_clk_stop_late: assert property ($fell(link_active) |-> $past(rate_setting, 300) == 3'h0)
    else $error("clock stopped too soon after rate cleared");
  a_underrun_pulse: assert property (underrun |-> link_active ##1 !underrun)
    else $error("underrun not a single pulse");

  // Main scenarios.
  c_link_stop: cover property ($fell(link_active));
  c_underrun: cover property (underrun);
  c_sync_rise: cover property ($rose(audio_frame_sync));
endmodule

bind audio_serial_master audio_link_chk chk (.mclk, .sys_rst, .stream_enable, .audio_bit_clock,
  .audio_frame_sync, .audio_data, .rate_setting, .link_active, .underrun);

// ===== verification/audio_input_device.sv
// Behavioural model of the audio input device that receives the link.
`timescale 1ns/100ps

// ============================================================
// Device model
module audio_input_device (
  // Link pins
  input wire logic               audio_bit_clock,
  input wire logic               audio_frame_sync,
  input wire logic               audio_data,
  // Device setting
  input wire logic [2:0]         rate_setting,
  input audio_tx_pkg::link_cfg_s cfg,
  // Received words
  output audio_tx_pkg::stereo_pair_s rx_pair,
  output int                     rx_count,
  output logic                   order_fault
);
  import audio_tx_pkg::*;
  logic        fs_prev = 1'b0;
  logic        ch;
  logic [23:0] w [2];
  int          k = 0;
  int          p;
  int          wl;
  real         last_t = 0.0;

  // Nothing received before the first frame.
  initial begin
    rx_pair = '0;
    rx_count = 0;
    order_fault = 1'b0;
  end

  // Bits are taken on the rising bit clock only.
  always @(posedge audio_bit_clock) begin
    wl = (cfg.wlen == WLEN_8) ? 8 : 12 + 4 * int'(cfg.wlen);
    if (cfg.fmt == FMT_DSP)
      k = (fs_prev && !audio_frame_sync) ? 1 : k + 1;
    else
      k = (fs_prev != audio_frame_sync) ? 1 : k + 1;
    p = k - ((cfg.fmt == FMT_I2S || (cfg.fmt == FMT_DSP && cfg.dsp_late)) ? 2 : 1);
    fs_prev = audio_frame_sync;
    ch = (cfg.fmt == FMT_DSP) ? (p >= wl) : (audio_frame_sync ^ (cfg.fmt != FMT_I2S));
    if (cfg.fmt == FMT_DSP && ch)
      p = p - wl;
    // disabled while the rate is zero
    if (rate_setting == 3'h0) begin
      w[0] = '0;
      w[1] = '0;
    end
    else if (p >= 0 && p < wl) begin
      if (p == 0)
        w[ch] = '0;
      w[ch][23-p] = audio_data;
      if (ch && p == wl - 1) begin
        rx_pair = {w[0], w[1]};
        rx_count++;
      end
    end
  end

  // clock lost while rate set needs a reset
  always @(posedge audio_bit_clock) last_t = $realtime;
  always #100 begin
    if (rate_setting != 3'h0 && $realtime - last_t > 1000.0)
      order_fault = 1'b1;
  end
endmodule

// ===== verification/testbench.sv
// Self-checking bench for the serial audio master.
`timescale 1ns/100ps

// ============================================================
// Bench top
module testbench;
  import audio_tx_pkg::*;
  logic         mclk = 1'b0;
  logic         sys_rst = 1'b1;
  logic         stream_enable = 1'b0;
  link_cfg_s    link_cfg = '0;
  logic         pair_valid = 1'b0;
  stereo_pair_s pair_data = '0;
  logic         pair_ready;
  logic         audio_bit_clock;
  logic         audio_frame_sync;
  logic         audio_data;
  logic [2:0]   rate_setting;
  logic         link_active;
  logic         underrun;
  logic         order_fault;
  stereo_pair_s rx_pair;
  int           rx_count;
  int           n_fail = 0;
  int           n_checks = 0;

  audio_serial_master dut (.mclk, .sys_rst, .stream_enable, .link_cfg, .pair_valid, .pair_ready, .pair_data,
    .audio_bit_clock, .audio_frame_sync, .audio_data, .rate_setting, .link_active, .underrun);
  audio_input_device dev (.audio_bit_clock, .audio_frame_sync, .audio_data, .rate_setting, .cfg(link_cfg),
    .rx_pair, .rx_count, .order_fault);

  // 125 MHz system clock.
  initial forever #4 mclk = ~mclk;

  // Compare and count.
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run.
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Offer one pair and hold it until the buffer takes it.
  task automatic push(input stereo_pair_s d);
    @(negedge mclk);
    pair_data = d;
    pair_valid = 1'b1;
    while (pair_ready !== 1'b1)
      @(negedge mclk);
    @(negedge mclk);
    pair_valid = 1'b0;
  endtask

  // One stream session: queue three pairs, enable, receive, drain, disable.
  task automatic run_cfg(input audio_fmt_e f, input logic late, input word_len_e wn, input logic [2:0] r);
    stereo_pair_s exp [3];
    logic [23:0]  m;
    int           i;
    int           c;
    int           n;
    m = ~(24'hFFFFFF >> ((wn == WLEN_8) ? 8 : 12 + 4 * int'(wn)));
    link_cfg = '{f, late, wn, r};
    for (i = 0; i < 3; i++) begin
      exp[i] = {24'hC35A96 ^ (24'(i) * 24'h111111), 24'h5AC3E1 + 24'(i)};
      push(exp[i]);
    end
    @(negedge mclk);
    stream_enable = 1'b1;
    n = rx_count;
    for (c = 0; c < 2000 && rate_setting === 3'h0; c++)
      @(negedge mclk);
    check(rate_setting, r);
    check(link_active, 1'b1);
    for (i = 0; i < 3; i++) begin
      for (c = 0; c < 9000 && !(rx_count != n && rx_pair !== '0); c++) begin
        n = rx_count;
        @(negedge mclk);
      end
      n = rx_count;
      check(rx_pair, {exp[i].left & m, exp[i].right & m});
    end
    for (c = 0; c < 3000 && underrun !== 1'b1; c++)
      @(negedge mclk);
    check(underrun, 1'b1);
    stream_enable = 1'b0;
    @(negedge mclk);
    check(rate_setting, 3'h0);
    for (c = 0; c < 5000 && link_active !== 1'b0; c++)
      @(negedge mclk);
    check(link_active, 1'b0);
    check(order_fault, 1'b0);
    $display("test done: format %0d late %0d", f, late);
  endtask

  // Main sequence.
  initial begin
    repeat (5) @(negedge mclk);
    sys_rst = 1'b0;
    check({rate_setting, link_active, audio_bit_clock, pair_ready}, 6'h01);
    run_cfg(FMT_I2S, 1'b0, WLEN_24, 3'h1);
    run_cfg(FMT_LEFT_JUST, 1'b0, WLEN_16, 3'h2);
    run_cfg(FMT_DSP, 1'b0, WLEN_8, 3'h3);
    run_cfg(FMT_DSP, 1'b1, WLEN_20, 3'h4);
    repeat (32) push(48'h123456ABCDEF);
    @(negedge mclk);
    check(pair_ready, 1'b0);
    sys_rst = 1'b1;
    repeat (5) @(negedge mclk);
    sys_rst = 1'b0;
    check(pair_ready, 1'b1);
    $display("test done: buffer full");
    finish_test();
  end

  // Sessions need about 13000 cycles each; a hang is cut short well beyond that.
  initial begin
    repeat (95000) @(posedge mclk);
    n_fail++;
    finish_test();
  end
endmodule
